/* File: src/fault_pkg.sv */
// Constants shared by the sensor fault response logic
package fault_pkg;
	// Register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'hC;
	// Status register fields
	localparam int ST_RESET_CLASS = 0;
	localparam int ST_REG_UV = 1;
	localparam int ST_RESERVE_LOW = 2;
	localparam int ST_RESERVE_LONG = 3;
	localparam int ST_CAPTEST = 4;
	localparam int ST_TIMEOUT = 5;
	localparam int ST_OTP_FAULT = 6;
	localparam int ST_SELFTEST_REQ = 7;
	localparam int ST_LOCKOUT = 8;
	localparam int ST_W = 9;
	// Interrupt event fields
	localparam int EV_RESET = 0;
	localparam int EV_DIP = 1;
	localparam int EV_OTP = 2;
	localparam int EV_LOCKOUT = 3;
	localparam int EV_W = 4;
	localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
	// Reply flag positions in the flags register and in replies
	localparam int FL_ERR = 1;
	localparam int FL_SELFTEST = 5;
	localparam int FL_RESERVE = 6;
	// Timing defaults in mclk cycles (50 MHz)
	localparam int CNT_W = 24;
	localparam int RESERVE_RESET_CYC = 2500;
	localparam int FRAME_TIMEOUT_CYC = 3000;
	localparam int CAPTEST_RETRY_CYC = 4000;
	localparam int SWITCH_OPEN_CYC = 4;
	localparam int RESET_PULSE_CYC = 16;
	localparam int SYNC_STAGES = 3;
	// Selection of what an acceleration reply carries
	typedef enum logic [1:0] {
		RESP_NORMAL,
		RESP_ZERO,
		RESP_SELFTEST
	} resp_sel_t;
	// Fault response modes in priority order
	typedef enum logic [2:0] {
		MODE_RESET,
		MODE_DIP,
		MODE_OTP,
		MODE_SELFTEST,
		MODE_NORMAL
	} fault_mode_t;
endpackage : fault_pkg

/* File: src/interval_timer.sv */
// Repeating interval timer, one-cycle tick per elapsed period
`timescale 1ns/1ps
module interval_timer #(
	parameter int CNT_W = 24,
	parameter int PERIOD = 1000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Run level and period tick
	input wire logic run,
	output logic tick
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	wire at_last = (cnt_r == LAST);

	assign cnt_nxt = (!run || at_last) ? '0 : cnt_r + 1'b1;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= run && at_last;
		end
	end
endmodule : interval_timer

/* File: src/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Pin and result
	input wire logic pin,
	output logic level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// Change accepted only when stages two and three agree
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			level <= RST_VAL;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level <= s3_r;
			end
		end
	end
endmodule : pin_sync

/* File: src/sensor_fault_response.sv */
// Fault and self-test exception handling of the satellite sensor
//
// Contract
// RULE1 - Regulator under-voltage holds device in reset
// RULE2 - Reset faults silence bus, open switch
// RULE3 - Master re-initialises after reset-class fault
// RULE4 - Short reserve dip, test off: 0/0/1
// RULE5 - Short reserve dip, test on: 0/1/1
// RULE6 - Long reserve low resets every period
// RULE7 - Capacitor test failure resets every retry
// RULE8 - Frame timeout resets every timeout period
// RULE9 - Factory OTP fault: error, short zero
// RULE10 - User OTP fault: error, short zero
// RULE11 - Self-test on: drive circuitry, 1/1/0
// RULE12 - Two disables enter self-test lockout
// RULE13 - Lockout: enable answered, test stays off
// RULE14 - Clear command or reset leaves lockout
// RULE15 - Error flag is reply bit one
// RULE16 - Reserve-low flag follows reserve pin comparator
// RULE17 - Fault times are cycle-count parameters
`timescale 1ns/1ps
module sensor_fault_response
	import fault_pkg::*;
#(
	parameter int RESERVE_RESET_CYCLES = fault_pkg::RESERVE_RESET_CYC, // RULE17
	parameter int FRAME_TIMEOUT_CYCLES = fault_pkg::FRAME_TIMEOUT_CYC, // RULE17
	parameter int CAPTEST_RETRY_CYCLES = fault_pkg::CAPTEST_RETRY_CYC, // RULE17
	parameter int SWITCH_OPEN_CYCLES = fault_pkg::SWITCH_OPEN_CYC, // RULE17
	parameter int RESET_PULSE_CYCLES = fault_pkg::RESET_PULSE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Analog comparator pins
	input wire logic core_regulator_low,
	input wire logic analog_regulator_low,
	input wire logic reserve_cap_pin_low,
	input wire logic captest_fail_pin,
	input wire logic bus_input_pin_low,
	// OTP integrity from the fuse checker
	input wire logic factory_crc_fail,
	input wire logic factory_lock,
	input wire logic user_mismatch,
	input wire logic user_lock,
	// Decoded bus commands, one-cycle pulses
	input wire logic cmd_enable_st,
	input wire logic cmd_disable_st,
	input wire logic cmd_clear,
	input wire logic cmd_other,
	// Register port
	input wire logic [fault_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [fault_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [fault_pkg::DATA_W-1:0] reg_rdata,
	// Device reset and bus control
	output logic device_reset,
	output logic bus_silent,
	output logic bus_switch_open,
	// Reply flags and reply selection
	output logic internal_error_flag,
	output logic selftest_active_flag,
	output logic reserve_low_flag,
	output fault_pkg::resp_sel_t short_resp_sel,
	output fault_pkg::resp_sel_t long_resp_sel,
	output logic selftest_drive,
	// Interrupt
	output logic irq
);
	import fault_pkg::*;

	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(RESET_PULSE_CYCLES - 1);
	localparam logic [CNT_W-1:0] OPEN_LAST = CNT_W'(SWITCH_OPEN_CYCLES - 1);

	// Synchronised comparator levels
	logic core_low_s;
	logic analog_low_s;
	logic reserve_low_s;
	logic captest_s;
	logic bus_low_s;

	pin_sync #(.RST_VAL(1'b1)) u_sync_core (
		.mclk(mclk),
		.resetn(resetn),
		.pin(core_regulator_low),
		.level(core_low_s)
	);
	pin_sync #(.RST_VAL(1'b1)) u_sync_analog (
		.mclk(mclk),
		.resetn(resetn),
		.pin(analog_regulator_low),
		.level(analog_low_s)
	);
	pin_sync #(.RST_VAL(1'b0)) u_sync_reserve (
		.mclk(mclk),
		.resetn(resetn),
		.pin(reserve_cap_pin_low),
		.level(reserve_low_s)
	);
	pin_sync #(.RST_VAL(1'b0)) u_sync_captest (
		.mclk(mclk),
		.resetn(resetn),
		.pin(captest_fail_pin),
		.level(captest_s)
	);
	pin_sync #(.RST_VAL(1'b0)) u_sync_bus (
		.mclk(mclk),
		.resetn(resetn),
		.pin(bus_input_pin_low),
		.level(bus_low_s)
	);

	// Regulator under-voltage; takes over every other fault
	wire reg_uv = core_low_s || analog_low_s;

	// Period timers
	logic reserve_tick;
	logic captest_tick;
	logic timeout_tick;

	interval_timer #(.CNT_W(CNT_W), .PERIOD(RESERVE_RESET_CYCLES)) u_reserve_timer (
		.mclk(mclk),
		.resetn(resetn),
		.run(reserve_low_s && !reg_uv),
		.tick(reserve_tick)
	);
	interval_timer #(.CNT_W(CNT_W), .PERIOD(CAPTEST_RETRY_CYCLES)) u_captest_timer (
		.mclk(mclk),
		.resetn(resetn),
		.run(captest_s && !reg_uv),
		.tick(captest_tick)
	);
	interval_timer #(.CNT_W(CNT_W), .PERIOD(FRAME_TIMEOUT_CYCLES)) u_timeout_timer (
		.mclk(mclk),
		.resetn(resetn),
		.run(bus_low_s && !reg_uv),
		.tick(timeout_tick)
	);

	// Fault state latches
	logic reserve_long_r;
	logic reserve_long_nxt;
	logic timeout_r;
	logic timeout_nxt;
	logic captest_prev_r;
	logic [CNT_W-1:0] pulse_cnt_r;
	logic [CNT_W-1:0] pulse_cnt_nxt;
	logic pulse_act_r;
	logic pulse_act_nxt;

	wire captest_rise = captest_s && !captest_prev_r;
	// Reset is repeated on every elapsed period while the fault stands
	wire reset_fire = !reg_uv && (reserve_tick || timeout_tick || captest_rise || captest_tick); // RULE6 RULE7 RULE8

	assign reserve_long_nxt = reserve_low_s && !reg_uv && (reserve_long_r || reserve_tick); // RULE6
	assign timeout_nxt = bus_low_s && !reg_uv && (timeout_r || timeout_tick); // RULE8

	assign pulse_cnt_nxt = reset_fire ? '0 : (pulse_act_r ? pulse_cnt_r + 1'b1 : pulse_cnt_r);
	assign pulse_act_nxt = reset_fire || (pulse_act_r && (pulse_cnt_r != PULSE_LAST));

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reserve_long_r <= 1'b0;
			timeout_r <= 1'b0;
			captest_prev_r <= 1'b0;
			pulse_cnt_r <= '0;
			pulse_act_r <= 1'b0;
		end else begin
			reserve_long_r <= reserve_long_nxt;
			timeout_r <= timeout_nxt;
			captest_prev_r <= captest_s;
			pulse_cnt_r <= pulse_cnt_nxt;
			pulse_act_r <= pulse_act_nxt;
		end
	end

	// Reset-class exceptions
	wire reset_class = reg_uv || reserve_long_r || captest_s || timeout_r || pulse_act_r; // RULE2
	wire reset_now = reg_uv || pulse_act_r; // RULE1

	// Switch opens within the switch-open count of the fault
	logic [CNT_W-1:0] open_cnt_r;
	logic [CNT_W-1:0] open_cnt_nxt;
	wire open_due = reset_class && (open_cnt_r == OPEN_LAST);

	assign open_cnt_nxt = !reset_class ? '0 : (open_due ? open_cnt_r : open_cnt_r + 1'b1);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			open_cnt_r <= '0;
		end else begin
			open_cnt_r <= open_cnt_nxt;
		end
	end

	// Self-test request and lockout
	logic st_req_r;
	logic st_req_nxt;
	logic lockout_r;
	logic lockout_nxt;
	logic last_disable_r;
	logic last_disable_nxt;

	wire other_cmd = cmd_enable_st || cmd_clear || cmd_other;
	wire lock_enter = cmd_disable_st && last_disable_r && !reset_class; // RULE12
	wire lock_leave = cmd_clear || reset_class || reserve_low_s; // RULE14

	assign last_disable_nxt = !reset_class && (cmd_disable_st || (last_disable_r && !other_cmd));
	assign lockout_nxt = !lock_leave && (lockout_r || lock_enter);
	// Enable in lockout is answered normally but grants nothing
	assign st_req_nxt = !reset_class && !cmd_clear && !cmd_disable_st &&
		(st_req_r || (cmd_enable_st && !lockout_r)); // RULE13

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_req_r <= 1'b0;
			lockout_r <= 1'b0;
			last_disable_r <= 1'b0;
		end else begin
			st_req_r <= st_req_nxt;
			lockout_r <= lockout_nxt;
			last_disable_r <= last_disable_nxt;
		end
	end

	// Response mode selection, highest priority first
	wire otp_fault = (factory_crc_fail && factory_lock) || (user_mismatch && user_lock); // RULE9 RULE10
	wire st_on = st_req_r && !lockout_r;
	fault_mode_t mode;

	assign mode = reset_class ? MODE_RESET :
		reserve_low_s ? MODE_DIP :
		otp_fault ? MODE_OTP :
		st_on ? MODE_SELFTEST : MODE_NORMAL;

	logic err_nxt;
	logic st_nxt;
	logic u_nxt;
	resp_sel_t short_nxt;
	resp_sel_t long_nxt;

	always_comb begin
		err_nxt = 1'b0;
		st_nxt = 1'b0;
		u_nxt = 1'b0;
		short_nxt = RESP_NORMAL;
		long_nxt = RESP_NORMAL;
		unique case (mode)
			MODE_RESET: begin
				err_nxt = 1'b1;
				st_nxt = 1'b1;
				short_nxt = RESP_ZERO;
				long_nxt = RESP_ZERO;
			end
			MODE_DIP: begin
				u_nxt = 1'b1; // RULE16
				st_nxt = st_on; // RULE5
				short_nxt = st_on ? RESP_SELFTEST : RESP_ZERO; // RULE4 RULE5
				long_nxt = st_on ? RESP_SELFTEST : RESP_NORMAL; // RULE4 RULE5
			end
			MODE_OTP: begin
				err_nxt = 1'b1; // RULE9 RULE10
				st_nxt = st_on;
				short_nxt = RESP_ZERO; // RULE9 RULE10
				long_nxt = st_on ? RESP_SELFTEST : RESP_NORMAL; // RULE9 RULE10
			end
			MODE_SELFTEST: begin
				err_nxt = 1'b1; // RULE11
				st_nxt = 1'b1; // RULE11
				short_nxt = RESP_SELFTEST; // RULE11
				long_nxt = RESP_SELFTEST; // RULE11
			end
			MODE_NORMAL: begin
				err_nxt = 1'b0; // RULE12 RULE15
			end
		endcase
	end

	// Registered outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			device_reset <= 1'b1;
			bus_silent <= 1'b1;
			bus_switch_open <= 1'b1;
			internal_error_flag <= 1'b1;
			selftest_active_flag <= 1'b1;
			reserve_low_flag <= 1'b0;
			short_resp_sel <= RESP_ZERO;
			long_resp_sel <= RESP_ZERO;
			selftest_drive <= 1'b0;
		end else begin
			device_reset <= reset_now; // RULE1 RULE6 RULE7 RULE8
			bus_silent <= reset_class; // RULE2
			bus_switch_open <= open_due || (bus_switch_open && reset_class); // RULE2
			internal_error_flag <= err_nxt; // RULE15
			selftest_active_flag <= st_nxt;
			reserve_low_flag <= u_nxt;
			short_resp_sel <= short_nxt;
			long_resp_sel <= long_nxt;
			selftest_drive <= st_on && !reset_class; // RULE11 RULE12
		end
	end

	// Interrupt events
	logic reset_prev_r;
	logic otp_prev_r;
	logic dip_prev_r;
	logic [EV_W-1:0] events;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			// Reset class stands after reset, so no false entry event
			reset_prev_r <= 1'b1;
			otp_prev_r <= 1'b0;
			dip_prev_r <= 1'b0;
		end else begin
			reset_prev_r <= reset_class;
			otp_prev_r <= otp_fault;
			dip_prev_r <= reserve_low_s;
		end
	end

	assign events[EV_RESET] = reset_class && !reset_prev_r;
	assign events[EV_DIP] = reserve_low_s && !dip_prev_r;
	assign events[EV_OTP] = otp_fault && !otp_prev_r;
	assign events[EV_LOCKOUT] = lock_enter;

	// Register port decode
	wire sel_status = (reg_addr == OFS_STATUS);
	wire sel_irq_stat = (reg_addr == OFS_IRQ_STAT);
	wire sel_irq_mask = (reg_addr == OFS_IRQ_MASK);
	wire sel_flags = (reg_addr == OFS_FLAGS);
	wire wr_irq_stat = reg_wr && sel_irq_stat;
	wire wr_irq_mask = reg_wr && sel_irq_mask;

	logic [EV_W-1:0] irq_stat_r;
	logic [EV_W-1:0] irq_stat_nxt;
	logic [EV_W-1:0] irq_mask_r;
	logic [EV_W-1:0] irq_mask_nxt;

	// New event wins over a write-one clear in the same cycle
	assign irq_stat_nxt = (irq_stat_r & ~(wr_irq_stat ? reg_wdata[EV_W-1:0] : '0)) | events;
	assign irq_mask_nxt = wr_irq_mask ? reg_wdata[EV_W-1:0] : irq_mask_r;

	wire [ST_W-1:0] status_word = {
		lockout_r, st_req_r, otp_fault, timeout_r, captest_s,
		reserve_long_r, reserve_low_s, reg_uv, reset_class
	};

	logic [DATA_W-1:0] flags_word;

	always_comb begin
		flags_word = '0;
		flags_word[FL_ERR] = internal_error_flag;
		flags_word[FL_SELFTEST] = selftest_active_flag;
		flags_word[FL_RESERVE] = reserve_low_flag;
	end

	wire [DATA_W-1:0] rd_mux =
		sel_status ? DATA_W'(status_word) :
		sel_irq_stat ? DATA_W'(irq_stat_r) :
		sel_irq_mask ? DATA_W'(irq_mask_r) :
		sel_flags ? flags_word : '0;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_r <= '0;
			irq_mask_r <= IRQ_MASK_RST;
			irq <= 1'b0;
			reg_rdata <= '0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq <= |(irq_stat_nxt & irq_mask_nxt);
			reg_rdata <= reg_rd ? rd_mux : '0;
		end
	end
endmodule : sensor_fault_response

/* File: tb/dsi_master_model.sv */
// Behavioural bus master driving decoded commands
`timescale 1ns/1ps
module dsi_master_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Requests from the bench
	input wire logic go,
	input wire logic [1:0] code,
	input wire logic rude,
	// Device side
	input wire logic bus_silent,
	output logic cmd_enable_st,
	output logic cmd_disable_st,
	output logic cmd_clear,
	output logic cmd_other,
	output logic [7:0] reinit_cnt
);
	logic silent_r;
	wire logic send = go && (rude || !bus_silent);
	wire logic back = silent_r && !bus_silent;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			silent_r <= 1'b1;
			reinit_cnt <= 8'h00;
			{cmd_enable_st, cmd_disable_st, cmd_clear, cmd_other} <= 4'h0;
		end else begin
			silent_r <= bus_silent;
			cmd_enable_st <= send && code == 2'h0;
			cmd_disable_st <= send && code == 2'h1;
			cmd_clear <= send && code == 2'h2;
			// Start-up sequence again after every silence
			cmd_other <= back || (send && code == 2'h3);
			reinit_cnt <= reinit_cnt + {7'h00, back};
		end
	end
endmodule : dsi_master_model

/* File: tb/fault_checker_properties.sv */
// Port-level checks of the fault response block
`timescale 1ns/1ps
module fault_checker_properties
	import fault_pkg::*;
#(
	parameter int FRAME_TIMEOUT_CYCLES = 20,
	parameter int SWITCH_OPEN_CYCLES = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Pins and commands
	input wire logic core_regulator_low,
	input wire logic analog_regulator_low,
	input wire logic reserve_cap_pin_low,
	input wire logic captest_fail_pin,
	input wire logic bus_input_pin_low,
	input wire logic cmd_enable_st,
	input wire logic cmd_disable_st,
	input wire logic cmd_clear,
	input wire logic cmd_other,
	// Watched outputs
	input wire logic device_reset,
	input wire logic bus_silent,
	input wire logic bus_switch_open,
	input wire logic internal_error_flag,
	input wire logic selftest_active_flag,
	input wire logic reserve_low_flag,
	input wire fault_pkg::resp_sel_t short_resp_sel,
	input wire fault_pkg::resp_sel_t long_resp_sel,
	input wire logic selftest_drive
);
	localparam int SW_LIM = SWITCH_OPEN_CYCLES + 1;
	localparam int TO_LIM = FRAME_TIMEOUT_CYCLES + 8;
	wire logic quiet = !cmd_enable_st && !cmd_disable_st && !cmd_clear && !cmd_other;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	sequence s_two_dis;
		(cmd_disable_st && !bus_silent) ##1 quiet ##1 (cmd_disable_st && !bus_silent);
	endsequence
	property p_reg_hold;
		((core_regulator_low [*8]) or (analog_regulator_low [*8])) |-> device_reset;
	endproperty
	a_reg_hold: assert property (p_reg_hold) else $error("reset not held under regulator low");
	property p_switch;
		$rose(bus_silent) |-> ##[0:SW_LIM] bus_switch_open;
	endproperty
	a_switch: assert property (p_switch) else $error("bus switch not opened in time");
	property p_dip_off;
		reserve_low_flag && !selftest_active_flag |->
			!internal_error_flag && short_resp_sel == RESP_ZERO && long_resp_sel == RESP_NORMAL;
	endproperty
	a_dip_off: assert property (p_dip_off) else $error("dip without self-test reply wrong");
	property p_dip_on;
		reserve_low_flag && selftest_active_flag |->
			!internal_error_flag && short_resp_sel == RESP_SELFTEST && long_resp_sel == RESP_SELFTEST;
	endproperty
	a_dip_on: assert property (p_dip_on) else $error("dip with self-test reply wrong");
	property p_otp;
		internal_error_flag && !selftest_active_flag |->
			!reserve_low_flag && short_resp_sel == RESP_ZERO && long_resp_sel == RESP_NORMAL;
	endproperty
	a_otp: assert property (p_otp) else $error("error without self-test reply wrong");
	property p_st_long;
		long_resp_sel == RESP_SELFTEST |-> selftest_active_flag;
	endproperty
	a_st_long: assert property (p_st_long) else $error("self-test data without flag");
	property p_lock;
		s_two_dis ##1 (!cmd_clear && !bus_silent && !reserve_cap_pin_low && !reserve_low_flag) [*6] |->
			!selftest_drive && !selftest_active_flag;
	endproperty
	a_lock: assert property (p_lock) else $error("self-test active during lockout");
	// Expected lockout from the command stream
	logic dis_seen_r;
	logic lock_exp_r;
	wire logic lock_kill = cmd_clear || bus_silent || reserve_cap_pin_low || reserve_low_flag;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dis_seen_r <= 1'b0;
			lock_exp_r <= 1'b0;
		end else begin
			dis_seen_r <= !bus_silent && (cmd_disable_st || (dis_seen_r && quiet));
			lock_exp_r <= !lock_kill && (lock_exp_r || (cmd_disable_st && dis_seen_r));
		end
	end
	property p_lock_en;
		lock_exp_r && cmd_enable_st && !lock_kill |->
			##2 (!selftest_drive && (bus_silent || !selftest_active_flag));
	endproperty
	a_lock_en: assert property (p_lock_en) else $error("enable granted during lockout");
	property p_timeout;
		$fell(device_reset) && bus_input_pin_low && !reserve_cap_pin_low && !captest_fail_pin |->
			##[1:TO_LIM] (device_reset || !bus_input_pin_low);
	endproperty
	a_timeout: assert property (p_timeout) else $error("frame timeout reset not repeated");
endmodule : fault_checker_properties

bind sensor_fault_response fault_checker_properties #(
	.FRAME_TIMEOUT_CYCLES(FRAME_TIMEOUT_CYCLES),
	.SWITCH_OPEN_CYCLES(SWITCH_OPEN_CYCLES)
) u_props (.*);

/* File: tb/testbench.sv */
// Self-checking bench for the sensor fault response block
`timescale 1ns/1ps
module testbench;
	import fault_pkg::*;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] pins = 5'h00;
	logic [3:0] otp = 4'h0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic go = 1'b0;
	logic rude = 1'b0;
	logic [1:0] code = 2'h0;
	logic cmd_enable_st, cmd_disable_st, cmd_clear, cmd_other;
	logic [DATA_W-1:0] reg_rdata;
	logic device_reset, bus_silent, bus_switch_open, selftest_drive, irq;
	logic internal_error_flag, selftest_active_flag, reserve_low_flag;
	resp_sel_t short_resp_sel, long_resp_sel;
	logic [7:0] reinit_cnt;
	int failures = 0;
	int checks = 0;
	int rises, falls, base;
	always #10 mclk = ~mclk;
	sensor_fault_response #(.RESERVE_RESET_CYCLES(20), .FRAME_TIMEOUT_CYCLES(20), .CAPTEST_RETRY_CYCLES(20),
		.SWITCH_OPEN_CYCLES(2), .RESET_PULSE_CYCLES(3)) DUT (
		.mclk, .resetn, .core_regulator_low(pins[0]), .analog_regulator_low(pins[1]),
		.reserve_cap_pin_low(pins[2]), .captest_fail_pin(pins[3]), .bus_input_pin_low(pins[4]),
		.factory_crc_fail(otp[3]), .factory_lock(otp[2]), .user_mismatch(otp[1]), .user_lock(otp[0]),
		.cmd_enable_st, .cmd_disable_st, .cmd_clear, .cmd_other, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .device_reset, .bus_silent, .bus_switch_open, .internal_error_flag, .selftest_active_flag,
		.reserve_low_flag, .short_resp_sel, .long_resp_sel, .selftest_drive, .irq);
	dsi_master_model partner (.mclk, .resetn, .go, .code, .rude, .bus_silent, .cmd_enable_st,
		.cmd_disable_st, .cmd_clear, .cmd_other, .reinit_cnt);
	task automatic fail(input string m);
		failures++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : fail
	task automatic chk_out(input logic [6:0] e);
		checks++;
		if ({internal_error_flag, selftest_active_flag, reserve_low_flag, short_resp_sel, long_resp_sel} !== e)
			fail("reply flags or selection");
	endtask : chk_out
	task automatic chk_b(input logic g, input logic e);
		checks++;
		if (g !== e) fail("control bit");
	endtask : chk_b
	task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) fail("word value");
	endtask : chk_v
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk_v(reg_rdata, e);
	endtask : rd
	// Codes: 0 enable, 1 disable, 2 clear, 3 other
	task automatic send(input logic [1:0] c);
		@(posedge mclk);
		go <= 1'b1;
		code <= c;
		@(posedge mclk);
		go <= 1'b0;
	endtask : send
	// Pins set while faulted also let the master talk over silence
	task automatic setp(input logic [4:0] p, input logic [3:0] o);
		@(posedge mclk);
		pins <= p;
		otp <= o;
		rude <= p != 5'h00;
	endtask : setp
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : wt
	task automatic watch(input int n);
		logic prev;
		#1;
		prev = device_reset;
		rises = 0;
		falls = 0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			rises += int'(device_reset && !prev);
			falls += int'(!device_reset && prev);
			prev = device_reset;
		end
	endtask : watch
	task automatic done(input int t);
		$display("test %0d finished, %0d checks so far", t, checks);
	endtask : done
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	// Whole run needs about 800 cycles
	initial begin
		#100000;
		fail("watchdog expired");
		give_verdict();
	end
	initial begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		wt(10);
		chk_b(device_reset, 1'b0);
		chk_out({3'h0, RESP_NORMAL, RESP_NORMAL});
		rd(OFS_IRQ_MASK, 32'h0);
		wr(OFS_IRQ_STAT, 32'hF);
		wr(OFS_IRQ_MASK, 32'h8);
		rd(4'h2, 32'h0);
		rd(OFS_IRQ_STAT, 32'h0);
		done(1);
		send(2'h0);
		wt(4);
		chk_out({3'h6, RESP_SELFTEST, RESP_SELFTEST});
		chk_b(selftest_drive, 1'b1);
		rd(OFS_FLAGS, 32'h22);
		rd(OFS_STATUS, 32'h80);
		setp(5'h04, 4'h0);
		wt(8);
		chk_out({3'h3, RESP_SELFTEST, RESP_SELFTEST});
		chk_b(device_reset, 1'b0);
		setp(5'h00, 4'h0);
		send(2'h1);
		setp(5'h04, 4'h0);
		wt(8);
		chk_out({3'h1, RESP_ZERO, RESP_NORMAL});
		chk_b(device_reset, 1'b0);
		setp(5'h00, 4'h0);
		wt(8);
		done(2);
		for (int i = 0; i < 2; i++) begin
			setp(5'h00, i ? 4'h3 : 4'hC);
			wt(4);
			chk_out({3'h4, RESP_ZERO, RESP_NORMAL});
			send(2'h0);
			wt(4);
			chk_out({3'h6, RESP_ZERO, RESP_SELFTEST});
			send(2'h1);
			setp(5'h00, 4'h0);
			wt(4);
		end
		done(3);
		send(2'h1);
		send(2'h1);
		wt(4);
		chk_out({3'h0, RESP_NORMAL, RESP_NORMAL});
		chk_b(irq, 1'b1);
		send(2'h0);
		wt(4);
		chk_out({3'h0, RESP_NORMAL, RESP_NORMAL});
		chk_b(selftest_drive, 1'b0);
		rd(OFS_IRQ_STAT, 32'hE);
		wr(OFS_IRQ_STAT, 32'h8);
		wt(2);
		chk_b(irq, 1'b0);
		send(2'h2);
		send(2'h0);
		wt(4);
		chk_b(selftest_drive, 1'b1);
		send(2'h3);
		send(2'h1);
		send(2'h1);
		done(4);
		for (int i = 0; i < 5; i++) begin
			base = int'(reinit_cnt);
			setp(5'h01 << i, 4'h0);
			wt(30);
			chk_b(bus_silent, 1'b1);
			chk_b(bus_switch_open, 1'b1);
			send(2'h0);
			watch(70);
			if (i < 2) chk_b(falls == 0 && device_reset, 1'b1);
			else chk_b(rises > 1, 1'b1);
			setp(5'h00, 4'h0);
			wt(20);
			chk_b(bus_switch_open, 1'b0);
			chk_b(selftest_drive, 1'b0);
			chk_v(32'(reinit_cnt), 32'(base + 1));
			send(2'h0);
			wt(4);
			chk_b(selftest_drive, 1'b1);
			send(2'h1);
		end
		done(5);
		give_verdict();
	end
endmodule : testbench
